// [src/angle_cfg_regs.vh]
`ifndef ANGLE_CFG_REGS_VH
`define ANGLE_CFG_REGS_VH
// =====
// Register offsets
`define OFS_PWM_LINK      8'h1B
`define OFS_ANGLE_PROC    8'h1C
`define OFS_LOW_POWER     8'h1D
`define OFS_COMMON        8'h1E
`define OFS_STATUS        8'h30
`define OFS_TURNS         8'h31
`define OFS_ALIVE         8'h32
// =====
// Reset values
`define RST_WORD          24'h000000
// =====
// pwm_and_link_options fields
`define B_SPI_CRC_CHECK   0
`define B_SKIP_EXTRA_EDGE 1
`define B_TURNS_HYST_SEL  2
`define B_OFFSET_STAGE    7
`define B_CORR_SPAN       10
`define B_LINEARIZE_ON    11
`define B_PWM_FAULT_STYLE 12
`define B_PWM_FAULT_ON    13
`define B_PWM_HYST_ON     14
`define B_PWM_OUTPUT_ON   23
// angle_processing_options fields
`define F_TRIM            11:0
`define F_HYST            17:12
`define B_SPIN_SENSE      18
`define B_HALF_FLIP       19
`define F_AVG_EXP         23:20
// low_power_options fields
`define F_WAKE_DELTA      10:0
`define B_TURNS_FROM_PLL  11
`define B_AUTO_TRANSPORT  11
`define F_SLEEP_PERIOD    17:12
`define F_SEED_MODE       19:18
`define B_LOW_POWER_DIS   20
`define B_TRANSPORT_DIS   21
`define B_STEP_SIZE_SEL   23
// common_options fields
`define F_FIELD_LOW       5:0
`define F_FIELD_HIGH      11:6
`define B_HARD_RST_BLOCK  12
// =====
// Timing and scaling
`define CLK_PERIOD_NS     40
`define SLEEP_UNIT_NS     8192000
`define SLEEP_UNIT_CYC    (`SLEEP_UNIT_NS / `CLK_PERIOD_NS)
`define AVG_EXP_MAX       4'hC
`define HALF_TURN         12'h800
`define LOW_FIELD_SHIFT   4
`define HIGH_FIELD_SHIFT  5
`endif

// [src/angle_output_config_bank.v]
// Summary of operation
// - CRC check on incoming frames when enabled
// - Skip seventeenth serial clock edge when set
// - Turns path uses filtered angle when selected
// - Stage select places zero offset before/after
// - Linearize when enabled; span 22.5 or 45
// - PWM fault: tristate latch or halved carrier
// - PWM angle filtered when its bit set
// - PWM pin driven only when enabled
// - Subtract 12-bit trim from measured angle
// - Hysteresis threshold counts 14-bit angle steps
// - Spin sense reverses angle after linearization
// - Half-turn flip adds 180 degrees, last
// - Average 2^exp samples, exponent clamped 12
// - Wake delta gates low-power entry and exit
// - Turns source zero-cross or PLL when locked and not in low power
// - Auto transport on low power, pins low
// - Sleep period (N+1) units; alive counter rate
// - Power-up turns seed by two-bit mode
// - Disable bits suppress low power, transport
// - Turns step at 45 or 180 degrees
// - Field limits code*16, code*32; zero disables
// - Block serial hard reset when bit set
// - Signed scaled correction subtracted per segment
//
// Strobed register access was decided locally.
`include "angle_cfg_regs.vh"
module angle_output_config_bank #(
    parameter SLEEP_UNIT = `SLEEP_UNIT_CYC
) (
    input  wire        CLK_SYS,
    input  wire        RST_N,
    input  wire [7:0]  REG_ADDR,
    input  wire [23:0] REG_WDATA,
    input  wire        REG_WR,
    input  wire        REG_RD,
    output reg  [23:0] REG_RDATA,
    input  wire [11:0] ANGLE_IN,
    input  wire        ANGLE_VALID,
    input  wire [11:0] LIN_CORR,
    output reg  [11:0] ANGLE_OUT,
    output reg         ANGLE_OUT_VALID,
    output wire [11:0] PWM_ANGLE,
    input  wire        PWM_GEN,
    input  wire        FAULT_PRESENT,
    output wire        PWM_O,
    output wire        PWM_OE_N,
    output wire        PWM_HALF_FREQ,
    output wire        PWM_SHOW_FAULT,
    input  wire [11:0] ZERO_CROSS_ANGLE,
    input  wire [11:0] PLL_ANGLE,
    input  wire        PLL_LOCKED,
    output reg  [15:0] TURNS_COUNT,
    output reg  [11:0] TURNS_ANGLE_REG,
    input  wire        SERIAL_PINS_LOW,
    input  wire        TRANSPORT_CMD,
    output wire        LOW_POWER_STATE,
    output wire        TRANSPORT_STATE,
    output reg  [31:0] ALIVE_COUNT,
    input  wire [11:0] FIELD_GAUSS,
    output reg         FIELD_LOW,
    output reg         FIELD_HIGH,
    output wire        SPI_CRC_CHECK,
    output wire        SKIP_EXTRA_EDGE,
    input  wire        HARD_RESET_CMD,
    output wire        HARD_RESET_REQ
);
    // =====
    // Wrapped absolute difference of two 14-bit angles
    function [13:0] wrap_abs;
        input [13:0] a;
        input [13:0] b;
        reg   [13:0] d;
        begin
            d = a - b;
            wrap_abs = d[13] ? (14'h0000 - d) : d;
        end
    endfunction

    // =====
    // Configuration words
    reg  [23:0] pwm_link_q;      // pwm_and_link_options
    reg  [23:0] angle_proc_q;    // angle_processing_options
    reg  [23:0] low_power_q;     // low_power_options
    reg  [23:0] common_q;        // common_options
    reg         fault_tri_q;     // Latched PWM tristate on fault
    reg  [2:0]  mode_q;          // Power mode state
    reg  [15:0] turns_q;         // Turns counter
    reg  [2:0]  sector_q;        // Last turns sector
    reg         seeded_q;        // Power-up seed taken
    localparam [2:0] ST_RUN   = 3'b001;
    localparam [2:0] ST_SLEEP = 3'b010;
    localparam [2:0] ST_SHIP  = 3'b100;
    // Field aliases
    wire       stage_sel = pwm_link_q[`B_OFFSET_STAGE];
    wire       lin_on    = pwm_link_q[`B_LINEARIZE_ON];
    wire       span      = pwm_link_q[`B_CORR_SPAN];
    wire [11:0] trim     = angle_proc_q[`F_TRIM];
    wire [5:0]  hyst_thr = angle_proc_q[`F_HYST];
    wire [3:0]  exp_raw  = angle_proc_q[`F_AVG_EXP];
    wire [3:0]  avg_exp  = (exp_raw > `AVG_EXP_MAX) ?
                           `AVG_EXP_MAX : exp_raw;

    // =====
    // Register writes
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pwm_link_q   <= `RST_WORD;
            angle_proc_q <= `RST_WORD;
            low_power_q  <= `RST_WORD;
            common_q     <= `RST_WORD;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `OFS_PWM_LINK:   pwm_link_q   <= REG_WDATA;
                `OFS_ANGLE_PROC: angle_proc_q <= REG_WDATA;
                `OFS_LOW_POWER:  low_power_q  <= REG_WDATA;
                `OFS_COMMON:     common_q     <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // =====
    // Register reads, data one cycle after strobe
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 24'h000000;
        end else begin
            case (REG_RD ? REG_ADDR : 8'h00)
                `OFS_PWM_LINK:   REG_RDATA <= pwm_link_q;
                `OFS_ANGLE_PROC: REG_RDATA <= angle_proc_q;
                `OFS_LOW_POWER:  REG_RDATA <= low_power_q;
                `OFS_COMMON:     REG_RDATA <= common_q;
                `OFS_STATUS:     REG_RDATA <= {17'h00000,
                    FIELD_HIGH, FIELD_LOW, fault_tri_q, mode_q,
                    seeded_q};
                `OFS_TURNS:      REG_RDATA <= {8'h00, turns_q};
                `OFS_ALIVE:      REG_RDATA <= ALIVE_COUNT[23:0];
                default:         REG_RDATA <= 24'h000000;
            endcase
        end
    end

    // =====
    // Angle path
    reg  [11:0] pre_off;     // Angle after early offset
    reg  [11:0] corr;        // Scaled correction
    reg  [11:0] lin;         // Linearized angle
    reg  [11:0] post_off;    // Angle after late offset
    reg  [11:0] spun;        // Angle after spin sense
    reg  [11:0] final_ang;   // Angle after flip
    always @* begin
        pre_off = stage_sel ? ANGLE_IN : ANGLE_IN - trim;
        // Correction full scale 22.5 or 45 degrees
        corr = span ? {{2{LIN_CORR[11]}}, LIN_CORR[11:2]}
                    : {{3{LIN_CORR[11]}}, LIN_CORR[11:3]};
        lin  = lin_on ? pre_off - corr : pre_off;
        post_off = stage_sel ? lin - trim : lin;
        spun = angle_proc_q[`B_SPIN_SENSE] ?
               12'h000 - post_off : post_off;
        final_ang = angle_proc_q[`B_HALF_FLIP] ?
                    spun + `HALF_TURN : spun;
    end
    reg  [11:0] proc_q;      // Processed angle
    reg         proc_vld_q;  // Processed sample strobe
    // Register processed angle
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            proc_q     <= 12'h000;
            proc_vld_q <= 1'b0;
        end else begin
            proc_vld_q <= ANGLE_VALID;
            if (ANGLE_VALID)
                proc_q <= final_ang;
        end
    end

    // =====
    // Averaging of 2^n processed samples
    reg  [23:0] acc_q;       // Running sum
    reg  [12:0] cnt_q;       // Samples in sum
    wire [23:0] acc_d = acc_q + {12'h000, proc_q};
    wire [12:0] cnt_d = cnt_q + 13'h0001;
    wire [23:0] avg_v = acc_d >> avg_exp;
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            acc_q           <= 24'h000000;
            cnt_q           <= 13'h0000;
            ANGLE_OUT       <= 12'h000;
            ANGLE_OUT_VALID <= 1'b0;
        end else begin
            ANGLE_OUT_VALID <= 1'b0;
            if (proc_vld_q) begin
                if (cnt_d == (13'h0001 << avg_exp)) begin
                    ANGLE_OUT       <= avg_v[11:0];
                    ANGLE_OUT_VALID <= 1'b1;
                    acc_q           <= 24'h000000;
                    cnt_q           <= 13'h0000;
                end else begin
                    acc_q <= acc_d;
                    cnt_q <= cnt_d;
                end
            end
        end
    end

    // =====
    // Hysteresis filter in 14-bit angle steps
    reg  [13:0] hyst_q;
    wire [13:0] ang14 = {proc_q, 2'b00};
    wire [11:0] hyst_ang = hyst_q[13:2];
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            hyst_q <= 14'h0000;
        else if (proc_vld_q &&
                 wrap_abs(ang14, hyst_q) > {8'h00, hyst_thr})
            hyst_q <= ang14;
    end

    // =====
    // PWM pin control
    wire fault_on = pwm_link_q[`B_PWM_FAULT_ON];
    wire style    = pwm_link_q[`B_PWM_FAULT_STYLE];
    wire fault_ev = fault_on & FAULT_PRESENT;
    // Tristate latch, set wins over clear
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            fault_tri_q <= 1'b0;
        else if (fault_ev && !style)
            fault_tri_q <= 1'b1;
        else if (!fault_on)
            fault_tri_q <= 1'b0;
    end
    assign PWM_ANGLE = pwm_link_q[`B_PWM_HYST_ON] ?
                       hyst_ang : proc_q;
    assign PWM_HALF_FREQ  = fault_ev & style;
    assign PWM_SHOW_FAULT = fault_ev & style;
    assign PWM_O    = PWM_GEN;
    assign PWM_OE_N = ~(pwm_link_q[`B_PWM_OUTPUT_ON] &
                        ~fault_tri_q);

    // =====
    // Turns counter
    wire lp_now = mode_q != ST_RUN;
    wire use_pll = low_power_q[`B_TURNS_FROM_PLL] &
                   ~lp_now & PLL_LOCKED;
    wire [11:0] base_ang = use_pll ? PLL_ANGLE : ZERO_CROSS_ANGLE;
    wire [11:0] turn_src = pwm_link_q[`B_TURNS_HYST_SEL] ?
                           hyst_ang : base_ang;
    wire step45 = low_power_q[`B_STEP_SIZE_SEL];
    wire [2:0] sector = step45 ? turn_src[11:9]
                               : {2'b00, turn_src[11]};
    wire [2:0] smask = step45 ? 3'h7 : 3'h1;
    wire [2:0] sdiff = (sector - sector_q) & smask;
    wire [1:0] seed  = low_power_q[`F_SEED_MODE];
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            turns_q         <= 16'h0000;
            sector_q        <= 3'h0;
            seeded_q        <= 1'b0;
            TURNS_ANGLE_REG <= 12'h000;
        end else if (proc_vld_q) begin
            TURNS_ANGLE_REG <= turn_src;
            sector_q        <= sector;
            if (!seeded_q) begin
                // First settled sample after power-up
                seeded_q <= 1'b1;
                if (seed == 2'b10)
                    turns_q <= {13'h0000, sector};
                else
                    turns_q <= 16'h0000;
            end else if (sdiff == 3'h1) begin
                turns_q <= turns_q + 16'h0001;
            end else if (sdiff == smask) begin
                turns_q <= turns_q - 16'h0001;
            end
        end
    end

    // Counter straight from its register
    always @* TURNS_COUNT = turns_q;
    // =====
    // Sleep period timer and alive counter
    reg  [31:0] unit_q;      // Cycles within one unit
    reg  [5:0]  per_q;       // Units within one period
    wire unit_end = unit_q == SLEEP_UNIT - 1;
    wire per_tick = unit_end &&
                    per_q == low_power_q[`F_SLEEP_PERIOD];
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            unit_q      <= 32'h00000000;
            per_q       <= 6'h00;
            ALIVE_COUNT <= 32'h00000000;
        end else begin
            unit_q <= unit_end ? 32'h00000000 : unit_q + 32'h1;
            if (per_tick) begin
                per_q       <= 6'h00;
                ALIVE_COUNT <= ALIVE_COUNT + 32'h1;
            end else if (unit_end) begin
                per_q <= per_q + 6'h01;
            end
        end
    end

    // =====
    // Power mode machine
    reg  [11:0] ref_q;       // Angle at last period tick
    wire [13:0] dlt = wrap_abs({proc_q, 2'b00}, {ref_q, 2'b00});
    wire [10:0] wake = low_power_q[`F_WAKE_DELTA];
    wire lp_dis = low_power_q[`B_LOW_POWER_DIS];
    wire tp_dis = low_power_q[`B_TRANSPORT_DIS];
    wire go_ship = ~tp_dis & (TRANSPORT_CMD |
        (low_power_q[`B_AUTO_TRANSPORT] & SERIAL_PINS_LOW));
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= ST_RUN;
            ref_q  <= 12'h000;
        end else begin
            if (per_tick)
                ref_q <= proc_q;
            case (mode_q)
                ST_RUN: begin
                    // Quiet over a period: enter low power
                    if (per_tick && !lp_dis &&
                        dlt[13:2] <= {1'b0, wake})
                        mode_q <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (lp_dis)
                        mode_q <= ST_RUN;
                    else if (per_tick &&
                             dlt[13:2] >= {1'b0, wake})
                        mode_q <= ST_RUN;
                    else if (go_ship)
                        mode_q <= ST_SHIP;
                end
                ST_SHIP: begin
                    if (tp_dis || lp_dis)
                        mode_q <= ST_RUN;
                end
                default: mode_q <= ST_RUN;
            endcase
        end
    end
    assign LOW_POWER_STATE = mode_q == ST_SLEEP;
    assign TRANSPORT_STATE = mode_q == ST_SHIP;

    // =====
    // Field limit comparators
    wire [5:0]  lo_code = common_q[`F_FIELD_LOW];
    wire [5:0]  hi_code = common_q[`F_FIELD_HIGH];
    wire [11:0] lo_lim  = {6'h00, lo_code} << `LOW_FIELD_SHIFT;
    wire [11:0] hi_lim  = {6'h00, hi_code} << `HIGH_FIELD_SHIFT;
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            FIELD_LOW  <= 1'b0;
            FIELD_HIGH <= 1'b0;
        end else begin
            FIELD_LOW  <= (lo_code != 6'h00) &&
                          (FIELD_GAUSS < lo_lim);
            FIELD_HIGH <= (hi_code != 6'h00) &&
                          (FIELD_GAUSS > hi_lim);
        end
    end
    // =====
    // Serial link options
    assign SPI_CRC_CHECK   = pwm_link_q[`B_SPI_CRC_CHECK];
    assign SKIP_EXTRA_EDGE = pwm_link_q[`B_SKIP_EXTRA_EDGE];
    assign HARD_RESET_REQ  = HARD_RESET_CMD &
                             ~common_q[`B_HARD_RST_BLOCK];
endmodule

// [test/angle_output_config_bank_assertions.sv]
`include "angle_cfg_regs.vh"
// =====
// Port checker for the option word bank
module angle_output_config_bank_checker (
    input wire        CLK_SYS,
    input wire        RST_N,
    input wire [7:0]  REG_ADDR,
    input wire [23:0] REG_WDATA,
    input wire        REG_WR,
    input wire        REG_RD,
    input wire [23:0] REG_RDATA,
    input wire        ANGLE_VALID,
    input wire        ANGLE_OUT_VALID,
    input wire        PWM_GEN,
    input wire        FAULT_PRESENT,
    input wire        PWM_O,
    input wire        PWM_OE_N,
    input wire        PWM_HALF_FREQ,
    input wire [11:0] FIELD_GAUSS,
    input wire        FIELD_LOW,
    input wire        SPI_CRC_CHECK,
    input wire        SKIP_EXTRA_EDGE,
    input wire        HARD_RESET_CMD,
    input wire        HARD_RESET_REQ
);
    // Shadow of the four words
    logic [23:0] sh_q [0:3];
    wire         map_a  = REG_ADDR >= `OFS_PWM_LINK && REG_ADDR <= `OFS_COMMON;
    wire         rd_map = REG_RD && map_a;
    wire  [1:0]  rd_ix  = REG_ADDR[1:0];
    wire  [23:0] pwm_and_link_options    = sh_q[3];
    wire  [23:0] common_options    = sh_q[2];
    wire  [5:0]  lo_cd  = common_options[`F_FIELD_LOW];
    wire  [3:0]  avg_e  = sh_q[0][`F_AVG_EXP];

    // Follow mapped host writes
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < 4; i++) begin
                sh_q[i] <= `RST_WORD;
            end
        end else if (REG_WR && map_a) begin
            sh_q[REG_ADDR[1:0]] <= REG_WDATA;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    AST_READ_BACK:
        assert property ($past(rd_map) |-> REG_RDATA == sh_q[$past(rd_ix)])
        else $error("read data differs from stored word");
    AST_CRC_BIT:
        assert property (SPI_CRC_CHECK == pwm_and_link_options[`B_SPI_CRC_CHECK])
        else $error("checksum enable differs from option bit");
    AST_SKIP_BIT:
        assert property (SKIP_EXTRA_EDGE == pwm_and_link_options[`B_SKIP_EXTRA_EDGE])
        else $error("edge skip differs from option bit");
    AST_PWM_OFF:
        assert property (!pwm_and_link_options[`B_PWM_OUTPUT_ON] |-> PWM_OE_N)
        else $error("pwm pin driven while disabled");
    AST_PWM_FOLLOW:
        assert property (!PWM_OE_N |-> PWM_O == PWM_GEN)
        else $error("pwm pin does not follow generator");
    AST_HALF_FREQ:
        assert property (PWM_HALF_FREQ == (pwm_and_link_options[`B_PWM_FAULT_ON]
            && pwm_and_link_options[`B_PWM_FAULT_STYLE] && FAULT_PRESENT))
        else $error("halved carrier differs from fault setup");
    AST_FAULT_TRI:
        assert property (pwm_and_link_options[`B_PWM_FAULT_ON] && !pwm_and_link_options[`B_PWM_FAULT_STYLE]
            && FAULT_PRESENT |=> PWM_OE_N [*2])
        else $error("pwm pin not released on fault");
    AST_HRST:
        assert property (HARD_RESET_REQ ==
            (HARD_RESET_CMD && !common_options[`B_HARD_RST_BLOCK]))
        else $error("hard reset request wrong");
    AST_FIELD_LO:
        assert property (FIELD_LOW == ($past(lo_cd) != 6'h00 &&
            $past(FIELD_GAUSS) < {2'h0, $past(lo_cd), 4'h0}))
        else $error("low field flag wrong");
    AST_OUT_EXP0:
        assert property (ANGLE_VALID && avg_e == 4'h0 |-> ##2 ANGLE_OUT_VALID)
        else $error("single sample gave no output");

    COV_OUT:  cover property (ANGLE_OUT_VALID);
    COV_HALF: cover property (PWM_HALF_FREQ);
    COV_LOW:  cover property (FIELD_LOW);
endmodule

// [test/config_host_model.sv]
// =====
// Host side of the register port
module config_host_model (
    input  wire         clk,
    input  wire  [23:0] rdata,
    output logic [7:0]  addr,
    output logic [23:0] wdata,
    output logic        wr_s,
    output logic        rd_s
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 24'h000000;
        wr_s = 1'b0;
        rd_s = 1'b0;
    end

    // One write strobe, lines parked inverted
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask

    // Read strobe, data in the next cycle
    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

// [test/tb_angle_output_config_bank.sv]
`include "angle_cfg_regs.vh"
`define CHECK(got, want) \
    begin \
        n_compared++; \
        if ((got) !== (want)) begin \
            err_total++; \
            $display("Error t=%0t got=%h exp=%h", $time, got, want); \
        end \
    end
// =====
// Bench top
module tb_angle_output_config_bank;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [23:0] pwm_and_link_options;
        logic [23:0] angle_processing_options;
        logic [11:0] ain;
        logic [11:0] corr;
        logic [11:0] res;
    } row_t;
    // Options, sample, expected output
    row_t rows [9] = '{
        '{24'h000000, 24'h000010, 12'h100, 12'h000, 12'h0F0},
        '{24'h000800, 24'h000000, 12'h100, 12'h040, 12'h0F8},
        '{24'h000C00, 24'h000000, 12'h100, 12'h040, 12'h0F0},
        '{24'h000C00, 24'h000000, 12'h100, 12'hFC0, 12'h110},
        '{24'h000000, 24'h000000, 12'h100, 12'h040, 12'h100},
        '{24'h000000, 24'h040000, 12'h100, 12'h000, 12'hF00},
        '{24'h000000, 24'h080000, 12'h100, 12'h000, 12'h900},
        '{24'h000000, 24'h0C0000, 12'h100, 12'h000, 12'h700},
        '{24'h000880, 24'h000010, 12'h100, 12'h040, 12'h0E8}
    };
    logic [7:0]  offs [4] = '{`OFS_PWM_LINK, `OFS_ANGLE_PROC,
                             `OFS_LOW_POWER, `OFS_COMMON};
    // Around the 32 G and 96 G limits
    logic [11:0] gs [4] = '{12'h01F, 12'h020, 12'h060, 12'h061};
    logic        clk_sys, rst_n, angle_valid, pwm_gen, fault, pins_low;
    logic        hrst_cmd;
    logic [11:0] angle_in, lin_corr, gauss;
    logic [23:0] rd_val;
    logic [31:0] a0;
    int          err_total, n_compared, cyc, vcount, n0;
    wire  [7:0]  addr;
    wire  [23:0] wdata, rdata;
    wire  [11:0] angle_out, pwm_ang;
    wire  [31:0] alive;
    wire         wr_s, rd_s, out_v, oe_n, pwm_o, half, show, lp, tp;
    wire         f_lo, f_hi, crc, skip, hreq;

    config_host_model host (.clk(clk_sys), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr_s(wr_s), .rd_s(rd_s));

    angle_output_config_bank #(.SLEEP_UNIT(8)) dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
        .ANGLE_IN(angle_in), .ANGLE_VALID(angle_valid), .LIN_CORR(lin_corr),
        .ANGLE_OUT(angle_out), .ANGLE_OUT_VALID(out_v), .PWM_ANGLE(pwm_ang),
        .PWM_GEN(pwm_gen), .FAULT_PRESENT(fault), .PWM_O(pwm_o),
        .PWM_OE_N(oe_n), .PWM_HALF_FREQ(half), .PWM_SHOW_FAULT(show),
        .ZERO_CROSS_ANGLE(12'h000), .PLL_ANGLE(12'h000), .PLL_LOCKED(1'b0),
        .TURNS_COUNT(), .TURNS_ANGLE_REG(), .SERIAL_PINS_LOW(pins_low),
        .TRANSPORT_CMD(1'b0), .LOW_POWER_STATE(lp), .TRANSPORT_STATE(tp),
        .ALIVE_COUNT(alive), .FIELD_GAUSS(gauss), .FIELD_LOW(f_lo),
        .FIELD_HIGH(f_hi), .SPI_CRC_CHECK(crc), .SKIP_EXTRA_EDGE(skip),
        .HARD_RESET_CMD(hrst_cmd), .HARD_RESET_REQ(hreq));

    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Hang guard and output pulse count
    always @(posedge clk_sys) begin
        cyc++;
        if (out_v === 1'b1) vcount++;
        if (cyc == 12000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One angle sample
    task automatic sample(input logic [11:0] a, input logic [11:0] c);
        @(posedge clk_sys);
        angle_in <= a;
        lin_corr <= c;
        angle_valid <= 1'b1;
        @(posedge clk_sys);
        angle_valid <= 1'b0;
    endtask

    // Bounded wait for the output pulse
    task automatic wait_out();
        for (int k = 0; k < 8 && out_v !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHECK(out_v, 1'b1)
    endtask

    // Main sequence
    initial begin
        {rst_n, angle_valid, fault, pins_low, hrst_cmd} = 5'h00;
        pwm_gen = 1'b1;
        {angle_in, lin_corr, gauss} = 36'h000000000;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            host.wr(`OFS_PWM_LINK, rows[i].pwm_and_link_options);
            host.wr(`OFS_ANGLE_PROC, rows[i].angle_processing_options);
            host.rd(`OFS_ANGLE_PROC, rd_val);
            `CHECK(rd_val, rows[i].angle_processing_options)
            sample(rows[i].ain, rows[i].corr);
            wait_out();
            `CHECK(angle_out, rows[i].res)
            `CHECK(pwm_ang, rows[i].res)
        end
        // Link option bits, all codes
        for (int v = 0; v < 4; v++) begin
            host.wr(`OFS_PWM_LINK, 24'(v));
            `CHECK(crc, v[0])
            `CHECK(skip, v[1])
        end
        // Pin enable, latched tristate on fault
        host.wr(`OFS_PWM_LINK, 24'h800000);
        `CHECK(oe_n, 1'b0)
        `CHECK(pwm_o, pwm_gen)
        host.wr(`OFS_PWM_LINK, 24'h000000);
        `CHECK(oe_n, 1'b1)
        host.wr(`OFS_PWM_LINK, 24'h802000);
        @(posedge clk_sys);
        fault <= 1'b1;
        @(posedge clk_sys);
        fault <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHECK(oe_n, 1'b1)
        host.wr(`OFS_PWM_LINK, 24'h800000);
        @(posedge clk_sys);
        #1;
        `CHECK(oe_n, 1'b0)
        // Fault as duty at half carrier
        host.wr(`OFS_PWM_LINK, 24'h803000);
        @(posedge clk_sys);
        fault <= 1'b1;
        #1;
        `CHECK(half, 1'b1)
        `CHECK(show, 1'b1)
        `CHECK(oe_n, 1'b0)
        @(posedge clk_sys);
        fault <= 1'b0;
        // Field limits: low code 2, high code 3
        host.wr(`OFS_COMMON, 24'h0000C2);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            gauss <= gs[i];
            @(posedge clk_sys);
            #1;
            `CHECK(f_lo, gs[i] < 12'h020)
            `CHECK(f_hi, gs[i] > 12'h060)
        end
        // Hard reset blocked, then allowed
        host.wr(`OFS_COMMON, 24'h001000);
        @(posedge clk_sys);
        hrst_cmd <= 1'b1;
        gauss <= 12'h000;
        #1;
        `CHECK(hreq, 1'b0)
        host.wr(`OFS_COMMON, 24'h000000);
        `CHECK(hreq, 1'b1)
        `CHECK(f_lo, 1'b0)
        @(posedge clk_sys);
        hrst_cmd <= 1'b0;
        // Two samples averaged, then clamped exponent 15
        host.wr(`OFS_ANGLE_PROC, 24'h100000);
        sample(12'h100, 12'h000);
        sample(12'h102, 12'h000);
        wait_out();
        `CHECK(angle_out, 12'h101)
        host.wr(`OFS_ANGLE_PROC, 24'hF00000);
        n0 = vcount;
        @(posedge clk_sys);
        angle_in <= 12'h200;
        angle_valid <= 1'b1;
        repeat (4096) @(posedge clk_sys);
        angle_valid <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHECK(vcount - n0, 1)
        `CHECK(angle_out, 12'h200)
        // Alive rate with low power off, then sleep entry and transport entry
        host.wr(`OFS_LOW_POWER, 24'h101000);
        a0 = alive;
        repeat (64) @(posedge clk_sys);
        #1;
        `CHECK(alive - a0, 32'h00000004)
        `CHECK(lp, 1'b0)
        @(posedge clk_sys);
        pins_low <= 1'b1;
        host.wr(`OFS_LOW_POWER, 24'h200900);
        repeat (40) @(posedge clk_sys);
        #1;
        `CHECK(lp, 1'b1)
        `CHECK(tp, 1'b0)
        host.wr(`OFS_LOW_POWER, 24'h000900);
        repeat (40) @(posedge clk_sys);
        #1;
        `CHECK(tp, 1'b1)
        // Unmapped: write dropped, read zero
        host.wr(8'h40, 24'hFFFFFF);
        host.rd(8'h40, rd_val);
        `CHECK(rd_val, 24'h000000)
        host.rd(`OFS_COMMON, rd_val);
        `CHECK(rd_val, 24'h000000)
        // Mid-run reset, reset values, read back
        @(posedge clk_sys);
        rst_n <= 1'b0;
        pins_low <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        `CHECK(oe_n, 1'b1)
        `CHECK(tp, 1'b0)
        for (int i = 0; i < 4; i++) begin
            host.rd(offs[i], rd_val);
            `CHECK(rd_val, `RST_WORD)
            host.wr(offs[i], 24'h5A5A5A);
            host.rd(offs[i], rd_val);
            `CHECK(rd_val, 24'h5A5A5A)
        end
        report_and_stop();
    end
endmodule

bind angle_output_config_bank angle_output_config_bank_checker u_chk (
    .CLK_SYS, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .ANGLE_VALID, .ANGLE_OUT_VALID, .PWM_GEN,
    .FAULT_PRESENT, .PWM_O, .PWM_OE_N, .PWM_HALF_FREQ, .FIELD_GAUSS,
    .FIELD_LOW, .SPI_CRC_CHECK, .SKIP_EXTRA_EDGE, .HARD_RESET_CMD,
    .HARD_RESET_REQ);
